// File: bcmc_map.svh
// register offsets, field positions, reset values and timing figures of the charge controller
`ifndef BCMC_MAP_SVH
`define BCMC_MAP_SVH

`define BCMC_CLK_HZ        40000000
`define BCMC_TICK_SEC      1
`define BCMC_PWM_HZ        2000

`define BCMC_OFF_CTRL      8'h00
`define BCMC_OFF_DUTY      8'h04
`define BCMC_OFF_LIMITS    8'h08
`define BCMC_OFF_EQTIME    8'h0c
`define BCMC_OFF_STATUS    8'h10
`define BCMC_OFF_IRQ_STAT  8'h14
`define BCMC_OFF_IRQ_MASK  8'h18

`define BCMC_CTRL_MODE     1:0
`define BCMC_CTRL_CELLS    7:4
`define BCMC_CTRL_CLRF     8
`define BCMC_DUTY_BASE     7:0
`define BCMC_LIM_TEMP      11:0
`define BCMC_LIM_INLOW     27:16
`define BCMC_EQTIME_SEC    15:0

`define BCMC_RST_CTRL      32'h0000_0020
`define BCMC_RST_DUTY      32'h0000_00ff
`define BCMC_RST_LIMITS    32'h0400_0800
`define BCMC_RST_EQTIME    32'h0000_a8c0
`define BCMC_RST_MASK      32'h0000_0000

`define BCMC_V_FLOAT_CHK   11'd1300
`define BCMC_V_EQ_HI       11'd1410
`define BCMC_V_EQ_MAX      11'd1500
`define BCMC_V_FLT_HI      11'd1390
`define BCMC_V_OVERCHG     11'd1450
`define BCMC_V_RELEASE     11'd1350

`define BCMC_EQ_HI_SEC     5'd20
`define BCMC_EQ_MAX_SEC    5'd2
`define BCMC_FLT_HI_SEC    5'd20
`define BCMC_OC_SEC        5'd10
`define BCMC_OC_WINDOW_SEC 16'd3600
`define BCMC_ALARM_CODE    16'h0080

`define BCMC_RESP_OKAY     2'b00
`define BCMC_RESP_SLVERR   2'b10

`endif

// File: bcmc_pkg.sv
// types of the charge controller
package bcmc_pkg;
  typedef enum logic [1:0] {SFLOATENTRY, SFLOAT, SEQUALIZE} bcmc_state_t;
  typedef enum logic [1:0] {OUTSTATICON, OUTPWM, OUTFORCEOFF} bcmc_outmode_t;
endpackage

// File: bcmc_pwm.sv
// fixed-period pwm generator for the charger control line
`timescale 1ns/100ps
module bcmc_pwm #(
  parameter int unsigned PERIOD = 20000
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] duty,
  output logic            pwmOut
);
  logic [15:0] cnt_ff;
  logic [31:0] prod;
  logic [15:0] thr;
  logic        pwm_ff;

  assign prod = PERIOD * {24'h000000, duty};
  assign thr  = prod[23:8];
  assign pwmOut = pwm_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff == 16'(PERIOD - 1)) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= (cnt_ff < thr);
    end
  end
endmodule

// File: bcmc_persist.sv
// persistence timer: condition must hold for a number of whole seconds
`timescale 1ns/100ps
module bcmc_persist #(
  parameter logic [4:0] LIMIT = 5'd20
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic tick,
  input  wire logic cond,
  output logic      hit,
  output logic      fire
);
  logic [4:0] cnt_ff;
  logic       fire_ff;

  assign hit  = (cnt_ff == LIMIT);
  assign fire = fire_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= 5'h00;
    end else if (!cond) begin
      cnt_ff <= 5'h00;
    end else if (tick && cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= cond && tick && (cnt_ff == LIMIT - 5'h01);
    end
  end
endmodule

// File: bcmc_top.sv
// battery charge mode controller with axi4-lite register slave
// How it works
// - charging allowed on mains, charger stopped whenever running on battery
// - charger control output is active low; low shuts the charger down
// - control output also offers a 2 kHz pwm mode setting current limit
// - pwm duty derived from input voltage, temperature and battery state
// - power-up starts in float entry
// - disconnected battery keeps the machine in float entry, except under float lock, which holds float
// - on float entry, above 13 V per cell stays float, else equalize
// - equalize above 14.1 V per cell for 20 s returns to float
// - equalize above 15 V per cell for 2 s returns to float
// - equalize time counter returns to float entry at limit, default 12 h, settable
// - float above 13.9 V per cell for 20 s flags charger fault 0080
// - above 14.5 V per cell for 10 s is overcharge, forces float
// - five overcharges in an hour: alarm, beeping, blinking icon, float lock
// - overcharge on battery inhibits mains transfer until below 13.5 V per cell
`timescale 1ns/100ps
`include "bcmc_map.svh"
module bcmc_top
  import bcmc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BCMC_CLK_HZ * `BCMC_TICK_SEC,
  parameter int unsigned PWM_PERIOD  = `BCMC_CLK_HZ / `BCMC_PWM_HZ
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        mainsMode,
  input  wire logic        batConnected,
  input  wire logic [15:0] batVolt,
  input  wire logic [11:0] inVolt,
  input  wire logic [11:0] temperature,
  output logic             chargerRunN,
  output logic             buzzer,
  output logic             batIcon,
  output logic             transferInhibit,
  output logic             irq,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  localparam int PINW = 42;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:5] == 3'h0) && (a[4:2] != 3'h7);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // string voltage above threshold times cells, same as per-cell voltage above threshold
  function automatic logic above(input logic [15:0] v, input logic [10:0] thr,
                                 input logic [3:0] cells);
    logic [15:0] lim;
    lim = 16'({thr, 4'h0} >> 4) * 16'({12'h000, cells});
    above = v > lim;
  endfunction

  logic [PINW-1:0] pinMeta_ff;
  logic [PINW-1:0] pinSync_ff;
  logic            mainsS;
  logic            batConnS;
  logic [15:0]     batVS;
  logic [11:0]     inVS;
  logic [11:0]     tempS;

  logic [31:0] ctrl_ff;
  logic [31:0] duty_ff;
  logic [31:0] limits_ff;
  logic [31:0] eqTime_ff;
  logic [31:0] mask_ff;
  logic [3:0]  irqStat_ff;

  logic        awHave_ff;
  logic        wHave_ff;
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        nxt_awHave;
  logic        nxt_wHave;
  logic        nxt_rvalid;
  logic        doWrite;
  logic        doRead;
  logic [31:0] rdMux;

  logic [25:0] tickCnt_ff;
  logic        tick_ff;
  logic [15:0] secNow_ff;
  bcmc_state_t state_ff;
  bcmc_state_t nxt_state;
  logic [15:0] eqSec_ff;
  logic        eqTimeUp;
  logic [3:0]  cells;
  logic [3:0]  cond;
  logic [3:0]  hit;
  logic [3:0]  fire;
  logic [15:0] ocTime_ff [4];
  logic [3:0]  ocValid_ff;
  logic        ocFire;
  logic        lockEvt;
  logic        locked_ff;
  logic        fault_ff;
  logic        inhibit_ff;
  logic [7:0]  nxt_duty;
  logic [7:0]  dutyEff_ff;
  logic        pwmOut;
  logic        chargeAllowCmd;
  logic        chargeStopCmd;
  logic        runN_ff;
  logic        buzzer_ff;
  logic        icon_ff;
  logic        irq_ff;
  logic [3:0]  evt;

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign chargerRunN     = runN_ff;
  assign buzzer          = buzzer_ff;
  assign batIcon         = icon_ff;
  assign transferInhibit = inhibit_ff;
  assign irq             = irq_ff;

  // two-stage pin synchroniser
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end else begin
      pinMeta_ff <= {mainsMode, batConnected, batVolt, inVolt, temperature};
      pinSync_ff <= pinMeta_ff;
    end
  end
  assign {mainsS, batConnS, batVS, inVS, tempS} = pinSync_ff;
  assign cells = ctrl_ff[`BCMC_CTRL_CELLS];

  // one-second tick and free-running seconds
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tickCnt_ff <= 26'h0;
      tick_ff    <= 1'b0;
      secNow_ff  <= 16'h0;
    end else begin
      tick_ff <= (tickCnt_ff == 26'(TICK_CYCLES - 1));
      tickCnt_ff <= (tickCnt_ff == 26'(TICK_CYCLES - 1)) ? 26'h0 : tickCnt_ff + 26'h1;
      if (tick_ff) begin
        secNow_ff <= secNow_ff + 16'h1;
      end
    end
  end

  // persistence conditions: eq hi, eq max, float hi, overcharge
  assign cond[0] = (state_ff == SEQUALIZE) && above(batVS, `BCMC_V_EQ_HI, cells);
  assign cond[1] = (state_ff == SEQUALIZE) && above(batVS, `BCMC_V_EQ_MAX, cells);
  assign cond[2] = (state_ff == SFLOAT) && above(batVS, `BCMC_V_FLT_HI, cells);
  assign cond[3] = above(batVS, `BCMC_V_OVERCHG, cells);

  localparam logic [4:0] DUR [4] = '{`BCMC_EQ_HI_SEC, `BCMC_EQ_MAX_SEC,
                                     `BCMC_FLT_HI_SEC, `BCMC_OC_SEC};
  for (genvar i = 0; i < 4; i++) begin : gTimer
    bcmc_persist #(.LIMIT(DUR[i])) uPersist (
      .clk  (clk),
      .nrst (nrst),
      .tick (tick_ff),
      .cond (cond[i]),
      .hit  (hit[i]),
      .fire (fire[i])
    );
  end
  assign ocFire = fire[3];

  // equalize elapsed time
  always_ff @(posedge clk) begin
    if (!nrst || state_ff != SEQUALIZE) begin
      eqSec_ff <= 16'h0;
    end else if (tick_ff && !eqTimeUp) begin
      eqSec_ff <= eqSec_ff + 16'h1;
    end
  end
  assign eqTimeUp = eqSec_ff >= eqTime_ff[`BCMC_EQTIME_SEC];

  // charge state machine
  always_comb begin
    nxt_state = state_ff;
    if (locked_ff) begin
      nxt_state = SFLOAT;
    end else if (!batConnS) begin
      nxt_state = SFLOATENTRY;
    end else begin
      case (state_ff)
        SFLOATENTRY: nxt_state = above(batVS, `BCMC_V_FLOAT_CHK, cells) ? SFLOAT : SEQUALIZE;
        SFLOAT:      nxt_state = SFLOAT;
        SEQUALIZE: begin
          if (hit[0] || hit[1] || eqTimeUp || ocFire) begin
            nxt_state = SFLOATENTRY;
          end
        end
        default:     nxt_state = SFLOATENTRY;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= SFLOATENTRY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // overcharge history over a sliding hour
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ocValid_ff <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ocTime_ff[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (tick_ff && (secNow_ff - ocTime_ff[i]) >= `BCMC_OC_WINDOW_SEC) begin
          ocValid_ff[i] <= 1'b0;
        end
      end
      if (ocFire) begin
        ocTime_ff[0]  <= secNow_ff;
        ocValid_ff[0] <= 1'b1;
        for (int i = 1; i < 4; i++) begin
          ocTime_ff[i]  <= ocTime_ff[i-1];
          ocValid_ff[i] <= ocValid_ff[i-1];
        end
      end
    end
  end
  assign lockEvt = ocFire && ocValid_ff[3] && !locked_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      locked_ff <= 1'b0;
    end else if (lockEvt) begin
      locked_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_ff <= 1'b0;
    end else if (fire[2]) begin
      fault_ff <= 1'b1;
    end else if (doWrite && awAddr_ff == `BCMC_OFF_CTRL && wStrb_ff[1] &&
                 wData_ff[`BCMC_CTRL_CLRF]) begin
      fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      inhibit_ff <= 1'b0;
    end else if (ocFire && !mainsS) begin
      inhibit_ff <= 1'b1;
    end else if (!above(batVS, `BCMC_V_RELEASE, cells)) begin
      inhibit_ff <= 1'b0;
    end
  end

  // duty selection
  always_comb begin
    nxt_duty = duty_ff[`BCMC_DUTY_BASE];
    if (tempS > limits_ff[`BCMC_LIM_TEMP]) begin
      nxt_duty = nxt_duty >> 1;
    end
    if (inVS < limits_ff[`BCMC_LIM_INLOW]) begin
      nxt_duty = nxt_duty >> 1;
    end
    if (state_ff != SEQUALIZE) begin
      nxt_duty = nxt_duty - (nxt_duty >> 2);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dutyEff_ff <= 8'h00;
    end else begin
      dutyEff_ff <= nxt_duty;
    end
  end

  bcmc_pwm #(.PERIOD(PWM_PERIOD)) uPwm (
    .clk    (clk),
    .nrst   (nrst),
    .duty   (dutyEff_ff),
    .pwmOut (pwmOut)
  );

  assign chargeAllowCmd = mainsS;
  assign chargeStopCmd  = !mainsS;

  always_ff @(posedge clk) begin
    if (!nrst || chargeStopCmd) begin
      runN_ff <= 1'b0;
    end else begin
      case (bcmc_outmode_t'(ctrl_ff[`BCMC_CTRL_MODE]))
        OUTSTATICON: runN_ff <= chargeAllowCmd;
        OUTPWM:      runN_ff <= pwmOut;
        OUTFORCEOFF: runN_ff <= 1'b0;
        default:     runN_ff <= 1'b0;
      endcase
    end
  end

  // lock-up annunciation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      buzzer_ff <= 1'b0;
      icon_ff   <= 1'b0;
    end else begin
      buzzer_ff <= locked_ff && (tickCnt_ff < 26'(TICK_CYCLES / 8));
      icon_ff   <= locked_ff ? (tickCnt_ff < 26'(TICK_CYCLES / 2)) : batConnS;
    end
  end

  // interrupt status, set wins over read clear
  assign evt = {nxt_state != state_ff, lockEvt, ocFire, fire[2]};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqStat_ff <= 4'h0;
      irq_ff     <= 1'b0;
    end else begin
      irqStat_ff <= evt | ((doRead && araddr == `BCMC_OFF_IRQ_STAT) ? 4'h0 : irqStat_ff);
      irq_ff     <= |(irqStat_ff & mask_ff[3:0]);
    end
  end

  // axi4-lite write channel
  assign doWrite    = awHave_ff && wHave_ff && !bvalid_ff;
  assign nxt_awHave = doWrite ? 1'b0 : (awHave_ff || (awvalid && awready_ff));
  assign nxt_wHave  = doWrite ? 1'b0 : (wHave_ff || (wvalid && wready_ff));

  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHave_ff  <= 1'b0;
      wHave_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      awAddr_ff  <= 8'h00;
      wData_ff   <= 32'h0;
      wStrb_ff   <= 4'h0;
    end else begin
      awHave_ff  <= nxt_awHave;
      wHave_ff   <= nxt_wHave;
      awready_ff <= !nxt_awHave;
      wready_ff  <= !nxt_wHave;
      if (awvalid && awready_ff) begin
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `BCMC_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= mapped(awAddr_ff) ? `BCMC_RESP_OKAY : `BCMC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff   <= `BCMC_RST_CTRL;
      duty_ff   <= `BCMC_RST_DUTY;
      limits_ff <= `BCMC_RST_LIMITS;
      eqTime_ff <= `BCMC_RST_EQTIME;
      mask_ff   <= `BCMC_RST_MASK;
    end else if (doWrite) begin
      case (awAddr_ff)
        `BCMC_OFF_CTRL:     ctrl_ff   <= merge(ctrl_ff, wData_ff, wStrb_ff) & 32'h0000_00f3;
        `BCMC_OFF_DUTY:     duty_ff   <= merge(duty_ff, wData_ff, wStrb_ff) & 32'h0000_00ff;
        `BCMC_OFF_LIMITS:   limits_ff <= merge(limits_ff, wData_ff, wStrb_ff) & 32'h0fff_0fff;
        `BCMC_OFF_EQTIME:   eqTime_ff <= merge(eqTime_ff, wData_ff, wStrb_ff) & 32'h0000_ffff;
        `BCMC_OFF_IRQ_MASK: mask_ff   <= merge(mask_ff, wData_ff, wStrb_ff) & 32'h0000_000f;
        default:            ;
      endcase
    end
  end

  // axi4-lite read channel
  assign doRead     = arvalid && arready_ff;
  assign nxt_rvalid = rvalid_ff ? !rready : doRead;

  always_comb begin
    case (araddr)
      `BCMC_OFF_CTRL:     rdMux = ctrl_ff;
      `BCMC_OFF_DUTY:     rdMux = duty_ff;
      `BCMC_OFF_LIMITS:   rdMux = limits_ff;
      `BCMC_OFF_EQTIME:   rdMux = eqTime_ff;
      `BCMC_OFF_STATUS:   rdMux = {(fault_ff || locked_ff) ? `BCMC_ALARM_CODE : 16'h0000,
                                   dutyEff_ff, ocValid_ff, inhibit_ff, locked_ff,
                                   state_ff == SEQUALIZE, fault_ff};
      `BCMC_OFF_IRQ_STAT: rdMux = {28'h0, irqStat_ff};
      `BCMC_OFF_IRQ_MASK: rdMux = mask_ff;
      default:            rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= `BCMC_RESP_OKAY;
    end else begin
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= !nxt_rvalid;
      if (doRead) begin
        rdata_ff <= rdMux;
        rresp_ff <= mapped(araddr) ? `BCMC_RESP_OKAY : `BCMC_RESP_SLVERR;
      end
    end
  end
endmodule

// File: bcmc_top_properties.sv
// port checks for the charge controller
`timescale 1ns/100ps
`include "bcmc_map.svh"
module bcmc_top_chk #(
  parameter int unsigned TICK_CYCLES = 20,
  parameter int unsigned PWM_PERIOD  = 40
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        mainsMode,
  input wire logic [15:0] batVolt,
  input wire logic        chargerRunN,
  input wire logic        buzzer,
  input wire logic        transferInhibit,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  // release level for the reset cell count of two
  localparam logic [15:0] RELV = 16'd2700;
  logic [7:0] buzzRun_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // length of the current beep
  always_ff @(posedge clk) begin
    if (!nrst || !buzzer) buzzRun_ff <= 8'h00;
    else if (buzzRun_ff != 8'hff) buzzRun_ff <= buzzRun_ff + 8'h01;
  end
  chk_batt_stop: assert property ((!mainsMode) [*5] |-> !chargerRunN)
    else $error("charger runs in battery mode");
  chk_inhibit_set: assert property ($rose(transferInhibit) |->
    !$past(mainsMode, 2) || !$past(mainsMode, 3) || !$past(mainsMode, 4))
    else $error("inhibit raised on mains");
  chk_inhibit_free: assert property ($fell(transferInhibit) |->
    $past(batVolt, 2) <= RELV || $past(batVolt, 3) <= RELV || $past(batVolt, 4) <= RELV)
    else $error("inhibit dropped at high voltage");
  chk_beep_short: assert property (buzzRun_ff <= 8'(TICK_CYCLES / 8 + 1))
    else $error("beep too long");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data not held");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_r_refuse: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  chk_aw_refuse: assert property (awvalid && awready |=> !awready)
    else $error("write address taken twice");
  chk_bad_addr: assert property (arvalid && arready && araddr >= 8'h1c |=>
    rresp == `BCMC_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property ($rose(transferInhibit));
  cover property ($rose(buzzer));
  cover property (arvalid && arready && araddr >= 8'h1c);
endmodule

bind bcmc_top bcmc_top_chk #(.TICK_CYCLES(TICK_CYCLES), .PWM_PERIOD(PWM_PERIOD)) i_bcmc_top_chk (
  .clk, .nrst, .mainsMode, .batVolt, .chargerRunN, .buzzer, .transferInhibit, .awvalid,
  .awready, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
  .rdata, .rresp);

// File: bcmc_charger_model.sv
// charger and battery stand-in: string voltage and presence
`timescale 1ns/100ps
module bcmc_charger_model (
  input  wire logic        clk,
  input  wire logic        chargerRunN,
  input  wire logic [15:0] setVolt,
  input  wire logic        present,
  output logic [15:0]      batVolt,
  output logic             batConnected
);
  // open string reads flat, charger state does not move the set level
  always_ff @(posedge clk) begin
    batConnected <= present;
    batVolt      <= present ? setVolt : 16'h0000;
  end
endmodule

// File: tb_battery_charge_mode_controller.sv
// self-checking bench for the charge controller
`timescale 1ns/100ps
module tb_battery_charge_mode_controller;
  localparam int TK = 20;
  logic        clk, nrst, mainsMode, present, batConnected;
  logic [15:0] setVolt, batVolt;
  logic [11:0] inVolt, temperature;
  logic        chargerRunN, buzzer, batIcon, transferInhibit, irq;
  logic [7:0]  awaddr, araddr, d, e8;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [65:0] e;
  logic [65:0] expQ[$];
  logic [1:0]  bQ[$];
  int          n_fail, cmp_count, cyc, hi, rsC, rsB, rsI;

  bcmc_top #(.TICK_CYCLES(TK), .PWM_PERIOD(40)) i_bcmc_top (.clk, .nrst, .mainsMode,
    .batConnected, .batVolt, .inVolt, .temperature, .chargerRunN, .buzzer, .batIcon,
    .transferInhibit, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  bcmc_charger_model i_bcmc_charger_model (.clk, .chargerRunN, .setVolt, .present,
    .batVolt, .batConnected);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  task automatic rst_seq;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bQ.push_back(r);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                    input logic [1:0] r);
    expQ.push_back({m, v, r});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  // counts high cycles of the charger line and rises of the three outputs
  task automatic watch(input int n);
    logic pc, pb, pi;
    hi = 0; rsC = 0; rsB = 0; rsI = 0;
    pc = chargerRunN; pb = buzzer; pi = batIcon;
    repeat (n) begin
      @(posedge clk);
      hi += chargerRunN;
      rsC += chargerRunN & ~pc;
      rsB += buzzer & ~pb;
      rsI += batIcon & ~pi;
      pc = chargerRunN; pb = buzzer; pi = batIcon;
    end
  endtask

  // result watcher and hang guard
  always @(posedge clk) begin
    cyc++;
    if (rvalid && rready && expQ.size() > 0) begin
      e = expQ.pop_front();
      check(rdata & e[65:34], e[33:2] & e[65:34]);
      check(32'(rresp), 32'(e[1:0]));
    end
    if (bvalid && bready && bQ.size() > 0) check(32'(bresp), 32'(bQ.pop_front()));
    if (cyc > 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  initial begin
    {nrst, awvalid, wvalid, arvalid, bready, rready} = '0;
    {mainsMode, present, wstrb} = {2'b11, 4'hf};
    {awaddr, araddr, wdata, d, e8} = '0;
    setVolt = 16'd2850;
    inVolt = 12'h800;
    temperature = 12'h100;
    void'($urandom(57));
    rst_seq();
    rd(8'h00, 32'h20, '1, 2'b00);
    rd(8'h04, 32'hff, '1, 2'b00);
    rd(8'h08, 32'h0400_0800, '1, 2'b00);
    rd(8'h0c, 32'd43200, '1, 2'b00);
    rd(8'h18, 32'h0, '1, 2'b00);
    rd(8'h1c, 32'h0, '1, 2'b10);
    wr(8'h1c, 32'hffff_ffff, 2'b10);
    wr(8'h10, 32'hffff_ffff, 2'b00);
    rd(8'h10, 32'h0, 32'h7, 2'b00);
    $display("register test done");
    check(chargerRunN, 1'b1);
    mainsMode <= 1'b0;
    repeat (6) @(posedge clk);
    check(chargerRunN, 1'b0);
    mainsMode <= 1'b1;
    wr(8'h00, 32'h22, 2'b00);
    repeat (4) @(posedge clk);
    check(chargerRunN, 1'b0);
    wr(8'h00, 32'h21, 2'b00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom_range(255, 16));
      temperature <= i[0] ? 12'h900 : 12'h100;
      inVolt <= i[1] ? 12'h300 : 12'h800;
      wr(8'h04, {24'h0, d}, 2'b00);
      e8 = d >> (int'(i[0]) + int'(i[1]));
      e8 = e8 - (e8 >> 2);
      repeat (4) @(posedge clk);
      rd(8'h10, {16'h0, e8, 8'h0}, 32'hff00, 2'b00);
    end
    temperature <= 12'h100;
    inVolt <= 12'h800;
    wr(8'h04, 32'h80, 2'b00);
    watch(80);
    watch(160);
    check(rsC, 4);
    check(hi inside {[58:62]}, 1'b1);
    $display("charger line test done");
    setVolt <= 16'd2500;
    rst_seq();
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h2, 32'h2, 2'b00);
    setVolt <= 16'd2850;
    tick(15);
    setVolt <= 16'd2500;
    tick(1);
    setVolt <= 16'd2850;
    tick(15);
    rd(8'h10, 32'h2, 32'h2, 2'b00);
    tick(6);
    rd(8'h10, 32'h0, 32'h3, 2'b00);
    wr(8'h18, 32'h1, 2'b00);
    tick(21);
    rd(8'h10, 32'h0080_0001, 32'hffff_0001, 2'b00);
    check(irq, 1'b1);
    wr(8'h18, 32'h0, 2'b00);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    rd(8'h14, 32'h1, 32'h1, 2'b00);
    wr(8'h18, 32'h1, 2'b00);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    setVolt <= 16'd2500;
    rst_seq();
    setVolt <= 16'd3100;
    tick(3);
    rd(8'h10, 32'h0, 32'h2, 2'b00);
    $display("equalize test done");
    setVolt <= 16'd2500;
    rst_seq();
    wr(8'h0c, 32'd3, 2'b00);
    present <= 1'b0;
    setVolt <= 16'd2500;
    tick(2);
    rd(8'h10, 32'h0, 32'h2, 2'b00);
    present <= 1'b1;
    tick(1);
    rd(8'h14, 32'h0, 32'h0, 2'b00);
    rd(8'h10, 32'h2, 32'h2, 2'b00);
    rd(8'h14, 32'h0, 32'h8, 2'b00);
    tick(3);
    rd(8'h14, 32'h8, 32'h8, 2'b00);
    $display("presence and time limit test done");
    rst_seq();
    mainsMode <= 1'b0;
    setVolt <= 16'd2950;
    tick(11);
    check(transferInhibit, 1'b1);
    rd(8'h10, 32'h8, 32'ha, 2'b00);
    setVolt <= 16'd2750;
    tick(1);
    check(transferInhibit, 1'b1);
    setVolt <= 16'd2650;
    tick(1);
    check(transferInhibit, 1'b0);
    mainsMode <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      setVolt <= 16'd2950;
      tick(11);
      setVolt <= 16'd2500;
      tick(1);
    end
    rd(8'h10, 32'h0080_0004, 32'hffff_0006, 2'b00);
    watch(60);
    check(rsB, 3);
    check(rsI, 3);
    present <= 1'b0;
    tick(1);
    present <= 1'b1;
    tick(1);
    rd(8'h10, 32'h4, 32'h6, 2'b00);
    $display("overcharge test done");
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
